/* File: product_quotient_regs.svh */
// Constants of the product/quotient unit: divider early-in skips and timing.
// Assumes inclusion by files that also import product_quotient_pkg.
`ifndef PRODUCT_QUOTIENT_REGS_SVH
`define PRODUCT_QUOTIENT_REGS_SVH

// ==========================================================
// Divider iteration counts
`define QUOT_FULL_ITER 6'h20
`define QUOT_SKIP_8    6'h17
`define QUOT_SKIP_16   6'h0F
`define QUOT_SKIP_24   6'h07
`define QUOT_SKIP_32   6'h00

// ==========================================================
// Divider latency in pipeline clocks, per dividend width
`define QUOT_LAT_8     6'h0C
`define QUOT_LAT_16    6'h13
`define QUOT_LAT_24    6'h1A
`define QUOT_LAT_32    6'h21

`endif

/* File: product_quotient_pkg.sv */
// Types shared by the product/quotient unit files.
// Assumes no other package defines the same names.
package product_quotient_pkg;

   // ==========================================================
   // Operation codes issued by the integer pipeline
   typedef enum logic [3:0] {
      OP_PROD        = 4'h0,
      OP_PRODU       = 4'h1,
      OP_ACC_ADD     = 4'h2,
      OP_ACC_ADDU    = 4'h3,
      OP_ACC_SUB     = 4'h4,
      OP_ACC_SUBU    = 4'h5,
      OP_PROD_RF     = 4'h6,
      OP_QUOT        = 4'h7,
      OP_QUOTU       = 4'h8,
      OP_MOVE_TOP    = 4'h9,
      OP_MOVE_BOTTOM = 4'hA
   } op_t;

   // ==========================================================
   // Divider sequencer states
   typedef enum logic {
      QUOT_IDLE = 1'b0,
      QUOT_RUN  = 1'b1
   } quot_state_t;

endpackage : product_quotient_pkg

/* File: booth_slice_multiplier.sv */
// Radix-4 booth multiplier: 33-bit signed operand times 17-bit signed slice.
// Purely combinational; the caller registers around it.
`timescale 1ns/1ps
module booth_slice_multiplier
   import product_quotient_pkg::*;
(
   input  wire logic        [32:0] multiplicand,
   input  wire logic        [16:0] multiplier_slice,
   output logic signed      [49:0] product
);

   logic        [18:0] bx;
   logic signed [49:0] a_ext;
   logic signed [49:0] acc [0:9];

   assign bx     = {multiplier_slice[16], multiplier_slice, 1'b0};
   assign a_ext  = {{17{multiplicand[32]}}, multiplicand};
   assign acc[0] = '0;

   // ==========================================================
   // One partial product per booth digit
   genvar i;
   generate
      for (i = 0; i < 9; i++)
      begin : g_digit
         logic signed [49:0] pp;
         always_comb
         begin
            case (bx[2*i+2 -: 3])
               3'h1, 3'h2: pp = a_ext;
               3'h3:       pp = a_ext <<< 1;
               3'h4:       pp = -(a_ext <<< 1);
               3'h5, 3'h6: pp = -a_ext;
               default:    pp = '0;
            endcase
         end
         assign acc[i+1] = acc[i] + (pp <<< (2 * i));
      end
   endgenerate

   assign product = acc[9];

endmodule : booth_slice_multiplier

/* File: iterative_divider.sv */
// Restoring divider, one quotient bit per clock, with early-in skipping.
// Assumes start is only raised while idle or in the finishing cycle; results are valid at finish.
`timescale 1ns/1ps
`include "product_quotient_regs.svh"
module iterative_divider
   import product_quotient_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic [31:0] dividend,
   input  wire logic [31:0] divisor,
   input  wire logic        is_unsigned,
   output logic             busy,
   output logic             almost_done,
   output logic             finish,
   output logic             fits_byte,
   output logic      [31:0] quotient,
   output logic      [31:0] remainder
);

   quot_state_t state_reg;
   logic [5:0]  iter_reg;
   logic [5:0]  cnt_reg;
   logic [31:0] quo_reg;
   logic [31:0] rem_reg;
   logic [31:0] dvs_reg;
   logic        neg_q_reg;
   logic        neg_r_reg;
   logic [31:0] abs_a;
   logic [31:0] abs_b;
   logic [5:0]  skip;
   logic [5:0]  lat;
   logic [32:0] shifted;
   logic [32:0] trial;
   logic [31:0] q_raw;
   logic [31:0] r_raw;
   logic        load;

   // ==========================================================
   // Early-in size detection from the dividend sign extension
   always_comb
   begin
      abs_a = (!is_unsigned && dividend[31]) ? -dividend : dividend;
      abs_b = (!is_unsigned && divisor[31]) ? -divisor : divisor;
      if (is_unsigned ? (dividend[31:8] == '0) : (&dividend[31:7] || ~|dividend[31:7]))
      begin
         skip = `QUOT_SKIP_8;
         lat  = `QUOT_LAT_8;
      end
      else if (is_unsigned ? (dividend[31:16] == '0) : (&dividend[31:15] || ~|dividend[31:15]))
      begin
         skip = `QUOT_SKIP_16;
         lat  = `QUOT_LAT_16;
      end
      else if (is_unsigned ? (dividend[31:24] == '0) : (&dividend[31:23] || ~|dividend[31:23]))
      begin
         skip = `QUOT_SKIP_24;
         lat  = `QUOT_LAT_24;
      end
      else
      begin
         skip = `QUOT_SKIP_32;
         lat  = `QUOT_LAT_32;
      end
   end

   assign fits_byte = (skip == `QUOT_SKIP_8);

   // ==========================================================
   // One restoring step
   assign shifted = {rem_reg, quo_reg[31]};
   assign trial   = shifted - {1'b0, dvs_reg};
   assign q_raw   = (iter_reg != '0) ? {quo_reg[30:0], ~trial[32]} : quo_reg;
   assign r_raw   = (iter_reg != '0) ? (trial[32] ? shifted[31:0] : trial[31:0]) : rem_reg;

   // Last step's result feeds the finish edge directly
   assign quotient    = neg_q_reg ? -q_raw : q_raw;
   assign remainder   = neg_r_reg ? -r_raw : r_raw;
   assign busy        = (state_reg == QUOT_RUN);
   assign almost_done = busy && (cnt_reg == 6'h02);
   assign finish      = busy && (cnt_reg == 6'h01);
   // A new divide may start on the edge that retires the previous one
   assign load        = start && (!busy || finish);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= QUOT_IDLE;
         iter_reg  <= '0;
         cnt_reg   <= '0;
         quo_reg   <= '0;
         rem_reg   <= '0;
         dvs_reg   <= '0;
         neg_q_reg <= 1'b0;
         neg_r_reg <= 1'b0;
      end
      else if (load)
      begin
         state_reg <= QUOT_RUN;
         iter_reg  <= `QUOT_FULL_ITER - skip;
         cnt_reg   <= lat - 6'h01;
         quo_reg   <= abs_a << skip;
         rem_reg   <= '0;
         dvs_reg   <= abs_b;
         neg_q_reg <= !is_unsigned && (dividend[31] ^ divisor[31]);
         neg_r_reg <= !is_unsigned && dividend[31];
      end
      else
      begin
         case (state_reg)
            QUOT_IDLE:
            begin
               state_reg <= QUOT_IDLE;
            end
            QUOT_RUN:
            begin
               if (iter_reg != '0)
               begin
                  iter_reg <= iter_reg - 6'h01;
                  quo_reg  <= q_raw;
                  rem_reg  <= r_raw;
               end
               cnt_reg <= cnt_reg - 6'h01;
               if (finish)
               begin
                  state_reg <= QUOT_IDLE;
               end
            end
            default:
            begin
               state_reg <= QUOT_IDLE;
            end
         endcase
      end
   end

endmodule : iterative_divider

/* File: product_quotient_unit.sv */
// Product/quotient unit beside the integer pipeline: multiplies, accumulates,
// divides and result-pair moves.
// Assumes the integer pipeline issues only while issue_ready is high.
//
// Operation
// - Unit pipeline runs alongside and never stalls with the integer pipeline.
// - Booth array is 32 by 16; only second operand sets pass count.
// - Second operand fitting 16 bits takes one pass, otherwise two.
// - Short multiplies accepted every cycle, long ones every other cycle.
// - Back-to-back long multiplies: the second waits one extra cycle.
// - Operand size is detected from values, not from the instruction.
// - Division produces one quotient bit per clock.
// - Dividend sign extension skips 23, 15 or 7 iterations.
// - Any unit instruction during a divide stalls until it finishes.
// - Result-pair multiplies: latency/rate 1/1 short, 2/2 long.
// - Register-file multiply: latency/rate 2/1 short, 3/2 long.
// - Divides take latency 12/19/26/33, rate 11/18/25/32 by dividend width.
// - Results go to the result pair; moves copy either half out.
// - Register-file multiply writes low product half to register file only.
// - Accumulate-add adds the product to the result pair.
// - Accumulate-subtract subtracts the product from the result pair.
`timescale 1ns/1ps
`include "product_quotient_regs.svh"
module product_quotient_unit
   import product_quotient_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire logic        issue_valid,
   input  op_t              issue_op,
   input  wire logic [31:0] primary_source_value,
   input  wire logic [31:0] secondary_source_value,
   input  wire logic [4:0]  issue_dest,
   output logic             issue_ready,
   output logic             quot_active,
   output logic             move_valid,
   output logic      [31:0] move_data,
   output logic      [4:0]  move_dest,
   output logic             regfile_write_valid,
   output logic      [31:0] regfile_write_data,
   output logic      [4:0]  regfile_write_dest
);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // ==========================================================
   // Issue decode
   logic        take;
   logic        is_prod;
   logic        is_quot;
   logic        is_move;
   logic        is_uns;
   logic        is_short;
   logic        issue_ready_reg;
   logic        issue_ready_next;

   assign take    = issue_valid && issue_ready_reg;
   assign is_prod = (issue_op <= OP_PROD_RF);
   assign is_quot = (issue_op == OP_QUOT) || (issue_op == OP_QUOTU);
   assign is_move = (issue_op == OP_MOVE_TOP) || (issue_op == OP_MOVE_BOTTOM);
   assign is_uns  = (issue_op == OP_PRODU) || (issue_op == OP_ACC_ADDU) ||
                    (issue_op == OP_ACC_SUBU) || (issue_op == OP_QUOTU);
   // Size from the second operand's value alone
   assign is_short = is_uns ? (secondary_source_value[31:16] == '0) :
                     (&secondary_source_value[31:15] || ~|secondary_source_value[31:15]);

   // ==========================================================
   // Multiplier stage
   logic        s1_valid_reg;
   op_t         s1_op_reg;
   logic [32:0] s1_a_reg;
   logic [31:0] s1_b_reg;
   logic        s1_uns_reg;
   logic        s1_long_reg;
   logic        s1_second_reg;
   logic [63:0] s1_partial_reg;
   logic [4:0]  s1_dest_reg;
   logic [16:0] slice;
   logic [49:0] slice_prod;
   logic [63:0] prod_ext;
   logic [63:0] final_prod;
   logic        s1_done;

   always_comb
   begin
      if (s1_second_reg)
      begin
         slice = {!s1_uns_reg && s1_b_reg[31], s1_b_reg[31:16]};
      end
      else if (s1_long_reg)
      begin
         slice = {1'b0, s1_b_reg[15:0]};
      end
      else
      begin
         slice = {!s1_uns_reg && s1_b_reg[15], s1_b_reg[15:0]};
      end
   end

   booth_slice_multiplier u_booth (
      .multiplicand     (s1_a_reg),
      .multiplier_slice (slice),
      .product          (slice_prod)
   );

   assign prod_ext   = {{14{slice_prod[49]}}, slice_prod};
   assign final_prod = s1_second_reg ? (s1_partial_reg + {prod_ext[47:0], 16'h0000}) : prod_ext;
   assign s1_done    = s1_valid_reg && (!s1_long_reg || s1_second_reg);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_valid_reg   <= 1'b0;
         s1_op_reg      <= OP_PROD;
         s1_a_reg       <= '0;
         s1_b_reg       <= '0;
         s1_uns_reg     <= 1'b0;
         s1_long_reg    <= 1'b0;
         s1_second_reg  <= 1'b0;
         s1_partial_reg <= '0;
         s1_dest_reg    <= '0;
      end
      else if (take && is_prod)
      begin
         s1_valid_reg  <= 1'b1;
         s1_op_reg     <= issue_op;
         s1_a_reg      <= {!is_uns && primary_source_value[31], primary_source_value};
         s1_b_reg      <= secondary_source_value;
         s1_uns_reg    <= is_uns;
         s1_long_reg   <= !is_short;
         s1_second_reg <= 1'b0;
         s1_dest_reg   <= issue_dest;
      end
      else if (s1_valid_reg && s1_long_reg && !s1_second_reg)
      begin
         s1_second_reg  <= 1'b1;
         s1_partial_reg <= prod_ext;
      end
      else
      begin
         s1_valid_reg  <= 1'b0;
         s1_second_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Divider
   logic        q_busy;
   logic        q_almost;
   logic        q_finish;
   logic        q_fits_byte;
   logic [31:0] q_quot;
   logic [31:0] q_rem;

   iterative_divider u_div (
      .core_clk    (core_clk),
      .resetn      (resetn),
      .start       (take && is_quot),
      .dividend    (primary_source_value),
      .divisor     (secondary_source_value),
      .is_unsigned (is_uns),
      .busy        (q_busy),
      .almost_done (q_almost),
      .finish      (q_finish),
      .fits_byte   (q_fits_byte),
      .quotient    (q_quot),
      .remainder   (q_rem)
   );

   // ==========================================================
   // Result pair
   logic [31:0] top_reg;
   logic [31:0] bottom_reg;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         top_reg    <= '0;
         bottom_reg <= '0;
      end
      else if (q_finish)
      begin
         {top_reg, bottom_reg} <= {q_rem, q_quot};
      end
      else if (s1_done)
      begin
         case (s1_op_reg)
            OP_ACC_ADD, OP_ACC_ADDU: {top_reg, bottom_reg} <= {top_reg, bottom_reg} + final_prod;
            OP_ACC_SUB, OP_ACC_SUBU: {top_reg, bottom_reg} <= {top_reg, bottom_reg} - final_prod;
            OP_PROD_RF:              {top_reg, bottom_reg} <= {top_reg, bottom_reg};
            default:                 {top_reg, bottom_reg} <= final_prod;
         endcase
      end
   end

   // ==========================================================
   // Register-file product path, one extra stage
   logic        rf_hold_valid_reg;
   logic [31:0] rf_hold_data_reg;
   logic [4:0]  rf_hold_dest_reg;
   logic        rf_valid_reg;
   logic [31:0] rf_data_reg;
   logic [4:0]  rf_dest_reg;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rf_hold_valid_reg <= 1'b0;
         rf_hold_data_reg  <= '0;
         rf_hold_dest_reg  <= '0;
         rf_valid_reg      <= 1'b0;
         rf_data_reg       <= '0;
         rf_dest_reg       <= '0;
      end
      else
      begin
         rf_hold_valid_reg <= s1_done && (s1_op_reg == OP_PROD_RF);
         rf_hold_data_reg  <= final_prod[31:0];
         rf_hold_dest_reg  <= s1_dest_reg;
         rf_valid_reg      <= rf_hold_valid_reg;
         rf_data_reg       <= rf_hold_data_reg;
         rf_dest_reg       <= rf_hold_dest_reg;
      end
   end

   // ==========================================================
   // Moves out of the result pair wait for the multiplier stage to drain
   logic        pend_reg;
   logic        pend_top_reg;
   logic [4:0]  pend_dest_reg;
   logic        move_valid_reg;
   logic [31:0] move_data_reg;
   logic [4:0]  move_dest_reg;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pend_reg       <= 1'b0;
         pend_top_reg   <= 1'b0;
         pend_dest_reg  <= '0;
         move_valid_reg <= 1'b0;
         move_data_reg  <= '0;
         move_dest_reg  <= '0;
      end
      else
      begin
         move_valid_reg <= 1'b0;
         if (take && is_move)
         begin
            pend_reg      <= 1'b1;
            pend_top_reg  <= (issue_op == OP_MOVE_TOP);
            pend_dest_reg <= issue_dest;
         end
         else if (pend_reg && !s1_valid_reg)
         begin
            pend_reg       <= 1'b0;
            move_valid_reg <= 1'b1;
            move_data_reg  <= pend_top_reg ? top_reg : bottom_reg;
            move_dest_reg  <= pend_dest_reg;
         end
      end
   end

   // ==========================================================
   // Issue interlock; it never looks at integer pipeline stalls
   always_comb
   begin
      if (take)
      begin
         issue_ready_next = !(is_quot || is_move || (is_prod && !is_short));
      end
      else if (pend_reg)
      begin
         issue_ready_next = !s1_valid_reg;
      end
      else if (q_busy)
      begin
         issue_ready_next = q_almost;
      end
      else
      begin
         issue_ready_next = 1'b1;
      end
   end

   logic quot_active_reg;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         issue_ready_reg <= 1'b1;
         quot_active_reg <= 1'b0;
      end
      else
      begin
         issue_ready_reg <= issue_ready_next;
         quot_active_reg <= (take && is_quot) || (q_busy && !q_finish);
      end
   end

   assign issue_ready         = issue_ready_reg;
   assign quot_active         = quot_active_reg;
   assign move_valid          = move_valid_reg;
   assign move_data           = move_data_reg;
   assign move_dest           = move_dest_reg;
   assign regfile_write_valid = rf_valid_reg;
   assign regfile_write_data  = rf_data_reg;
   assign regfile_write_dest  = rf_dest_reg;

   // ==========================================================
   // Checks
   property p_long_gap;
      take && is_prod && !is_short |=> !issue_ready ##1 issue_ready;
   endproperty
   a_long_gap: assert property (p_long_gap) else $error("long multiply gap wrong");

   property p_short_rate;
      take && is_prod && is_short |=> issue_ready;
   endproperty
   a_short_rate: assert property (p_short_rate) else $error("short multiply blocked");

   property p_short_result;
      take && issue_op == OP_PRODU && is_short |->
         ##2 {top_reg, bottom_reg} == {32'h0000_0000, $past(primary_source_value, 2)} *
                                      {32'h0000_0000, $past(secondary_source_value, 2)};
   endproperty
   a_short_result: assert property (p_short_result) else $error("short product wrong");

   property p_long_result;
      take && issue_op == OP_PRODU && !is_short |->
         ##3 {top_reg, bottom_reg} == {32'h0000_0000, $past(primary_source_value, 3)} *
                                      {32'h0000_0000, $past(secondary_source_value, 3)};
   endproperty
   a_long_result: assert property (p_long_result) else $error("long product wrong");

   property p_rf_latency;
      take && issue_op == OP_PROD_RF && is_short |->
         ##3 regfile_write_valid && regfile_write_data ==
            32'($past(primary_source_value, 3) * $past(secondary_source_value, 3));
   endproperty
   a_rf_latency: assert property (p_rf_latency) else $error("register-file product late");

   property p_acc_add;
      take && issue_op == OP_ACC_ADDU && is_short && !s1_valid_reg && !q_busy |->
         ##2 {top_reg, bottom_reg} == $past({top_reg, bottom_reg}, 2) +
            {32'h0000_0000, $past(primary_source_value, 2)} * {32'h0000_0000, $past(secondary_source_value, 2)};
   endproperty
   a_acc_add: assert property (p_acc_add) else $error("accumulate wrong");

   property p_byte_quot_rate;
      take && is_quot && q_fits_byte |=>
         (!issue_ready)[*8] ##1 !issue_ready ##1 !issue_ready ##1 issue_ready;
   endproperty
   a_byte_quot_rate: assert property (p_byte_quot_rate) else $error("divide repeat wrong");

   property p_byte_quot_value;
      take && issue_op == OP_QUOTU && q_fits_byte && secondary_source_value != '0 |->
         ##12 bottom_reg == $past(primary_source_value, 12) / $past(secondary_source_value, 12) &&
              top_reg == $past(primary_source_value, 12) % $past(secondary_source_value, 12);
   endproperty
   a_byte_quot_value: assert property (p_byte_quot_value) else $error("divide result wrong");

   property p_move_wait;
      take && is_move |-> ##[2:4] move_valid;
   endproperty
   a_move_wait: assert property (p_move_wait) else $error("move never answered");

endmodule : product_quotient_unit

/* File: int_pipe_model.sv */
// Model of the integer pipeline that issues operations to the product/quotient unit.
// Assumes the bench calls issue and idle just after a rising clock edge.
`timescale 1ns/1ps
module int_pipe_model
   import product_quotient_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        issue_ready,
   output logic             issue_valid,
   output op_t              issue_op,
   output logic      [31:0] primary_source_value,
   output logic      [31:0] secondary_source_value,
   output logic      [4:0]  issue_dest
);
   initial
   begin
      issue_valid = 1'b0;
      issue_op = OP_PROD;
      primary_source_value = 32'h0000_0000;
      secondary_source_value = 32'h0000_0000;
      issue_dest = 5'h00;
   end

   // Holds the operation unchanged until an edge that finds issue_ready high
   task automatic issue(input op_t op, input logic [31:0] a, input logic [31:0] b, input logic [4:0] d);
      logic taken;
      issue_valid = 1'b1;
      issue_op = op;
      primary_source_value = a;
      secondary_source_value = b;
      issue_dest = d;
      do
      begin
         taken = issue_ready;
         @(posedge core_clk);
         #1;
      end while (taken !== 1'b1);
   endtask : issue

   // Released operand lines show the inverse of their last value
   task automatic idle();
      issue_valid = 1'b0;
      primary_source_value = ~primary_source_value;
      secondary_source_value = ~secondary_source_value;
      @(posedge core_clk);
      #1;
   endtask : idle
endmodule : int_pipe_model

/* File: product_quotient_unit_tb_top.sv */
// Self-checking bench of the product/quotient unit.
// Assumes int_pipe_model as the issuing side; results are checked against queued notes.
`timescale 1ns/1ps
`define CMP(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module product_quotient_unit_tb_top;
   import product_quotient_pkg::*;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        issue_valid, issue_ready, quot_active, move_valid, regfile_write_valid;
   op_t         issue_op;
   logic [31:0] primary_source_value, secondary_source_value, move_data, regfile_write_data, a, b;
   logic [4:0]  issue_dest, move_dest, regfile_write_dest;
   logic [36:0] mv_q[$];
   logic [36:0] rf_q[$];
   logic [36:0] note;
   logic [63:0] pair = 64'h0000_0000_0000_0000;
   logic [31:0] seed = 32'h8cd2_2633;
   int          failures = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #4 core_clk = ~core_clk;

   product_quotient_unit DUT (.core_clk, .resetn, .issue_valid, .issue_op, .primary_source_value,
      .secondary_source_value, .issue_dest, .issue_ready, .quot_active, .move_valid, .move_data,
      .move_dest, .regfile_write_valid, .regfile_write_data, .regfile_write_dest);
   int_pipe_model PIPE (.core_clk, .issue_ready, .issue_valid, .issue_op, .primary_source_value,
      .secondary_source_value, .issue_dest);

   // ==========================================================
   // Stimulus helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic wait_ready(input int e);
      int n = 0;
      while (issue_ready !== 1'b1 && n < 64)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
      `CMP(n, e)
   endtask : wait_ready

   task automatic mv(input logic [4:0] d);
      mv_q.push_back({d, pair[63:32]});
      PIPE.issue(OP_MOVE_TOP, 32'h0000_0000, 32'h0000_0000, d);
      mv_q.push_back({d, pair[31:0]});
      PIPE.issue(OP_MOVE_BOTTOM, 32'h0000_0000, 32'h0000_0000, d);
      PIPE.idle();
   endtask : mv

   task automatic mul(input op_t op, input logic [31:0] x, input logic [31:0] y, input logic [4:0] d);
      logic        sg;
      logic        lng;
      logic [63:0] p;
      sg = (op == OP_PROD || op == OP_ACC_ADD || op == OP_ACC_SUB || op == OP_PROD_RF);
      p = sg ? {{32{x[31]}}, x} * {{32{y[31]}}, y} : {32'h0000_0000, x} * {32'h0000_0000, y};
      lng = sg ? (y[31:15] != {17{y[15]}}) : (y[31:16] != 16'h0000);
      case (op)
         OP_ACC_ADD, OP_ACC_ADDU: pair += p;
         OP_ACC_SUB, OP_ACC_SUBU: pair -= p;
         OP_PROD_RF: rf_q.push_back({d, p[31:0]});
         default: pair = p;
      endcase
      PIPE.issue(op, x, y, d);
      wait_ready(int'(lng));
   endtask : mul

   task automatic div(input logic sg, input logic [31:0] x, input logic [31:0] y);
      int w = 31;
      if (sg ? (x[31:23] == {9{x[23]}}) : (x[31:24] == 8'h00)) w = 24;
      if (sg ? (x[31:15] == {17{x[15]}}) : (x[31:16] == 16'h0000)) w = 17;
      if (sg ? (x[31:7] == {25{x[7]}}) : (x[31:8] == 24'h00_0000)) w = 10;
      pair = sg ? {32'($signed(x) % $signed(y)), 32'($signed(x) / $signed(y))} : {x % y, x / y};
      PIPE.issue(sg ? OP_QUOT : OP_QUOTU, x, y, 5'h00);
      `CMP(quot_active, 1'b1)
      wait_ready(w);
      mv(x[4:0]);
      `CMP(quot_active, 1'b0)
   endtask : div

   // ==========================================================
   // Result watcher
   always @(posedge core_clk)
   begin
      #2;
      if (move_valid === 1'b1)
      begin
         note = mv_q.pop_front();
         `CMP({move_dest, move_data}, note)
      end
      if (regfile_write_valid === 1'b1)
      begin
         note = rf_q.pop_front();
         `CMP({regfile_write_dest, regfile_write_data}, note)
      end
   end

   // ==========================================================
   // Main sequence and closing
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         report_and_stop();
      end
   end

   initial
   begin
      repeat (5) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      for (int i = 0; i < 28; i++)
      begin
         a = rnd();
         b = rnd();
         if (!i[1])
            b = {{16{b[15]}}, b[15:0]};
         mul(op_t'(i % 7), a, b, a[4:0]);
         if (i % 3 == 2)
            mv(b[4:0]);
      end
      for (int k = 0; k < 8; k++)
      begin
         a = rnd();
         b = rnd();
         div(k[0], k[0] ? 32'($signed(a) >>> (k[2:1] * 8)) : a >> (k[2:1] * 8), (b >> 20) | 32'h0000_0001);
      end
      repeat (5) @(posedge core_clk);
      `CMP(mv_q.size() + rf_q.size(), 0)
      report_and_stop();
   end
endmodule : product_quotient_unit_tb_top
